// file: adcsc_map.svh
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH

// ****************************************
// control and status word bit positions
// ****************************************
`define ADCSC_SB_ZERO    15
`define ADCSC_SB_BUSY    14
`define ADCSC_CB_SGL     13
`define ADCSC_CB_CH_HI   12
`define ADCSC_CB_CH_LO   10
`define ADCSC_CB_PM_HI   9
`define ADCSC_CB_PM_LO   8
`define ADCSC_CB_RB_HI   7
`define ADCSC_CB_RB_LO   6
`define ADCSC_CB_MODE    5
`define ADCSC_SB_DONT    4
`define ADCSC_CB_KIND    3
`define ADCSC_CB_TGT_HI  2
`define ADCSC_CB_TGT_LO  1
`define ADCSC_CB_START   0

// ****************************************
// reset values and fixed fields
// ****************************************
`define ADCSC_STAT_RST   16'h0000
`define ADCSC_RD_RST     16'h0000
`define ADCSC_STAT_ID    2'h3
`define ADCSC_RD_LEAD    2'h0
`define ADCSC_CAL_RST    14'h0000

// ****************************************
// calibration register indices
// ****************************************
`define ADCSC_IDX_GAIN   4'h0
`define ADCSC_IDX_OFF    4'h1
`define ADCSC_IDX_LAST   4'h9

`endif

// file: adcsc_pkg.sv
package adcsc_pkg;

    // calibration target select, in field order 00..11
    typedef enum logic [1:0] {
        ADCSC_TGT_ALL,
        ADCSC_TGT_GAIN_OFF,
        ADCSC_TGT_OFF,
        ADCSC_TGT_GAIN
    } adcsc_tgt_t;

    // readback select, in field order 00..11
    typedef enum logic [1:0] {
        ADCSC_RB_RES_A,
        ADCSC_RB_RES_B,
        ADCSC_RB_CAL,
        ADCSC_RB_STAT
    } adcsc_rb_t;

    typedef struct packed {
        logic       alive;
        logic       sgl;
        logic [2:0] ch;
        logic [1:0] pm;
        adcsc_rb_t  rb;
        logic       mode;
        logic       kind;
        adcsc_tgt_t tgt;
        logic       cal_run;
        logic [3:0] ptr;
        logic [15:0] status;
        logic [15:0] rd_data;
        logic       rd_valid;
    } adcsc_top_st_t;

endpackage : adcsc_pkg

// file: adcsc_cal_file.sv
`timescale 1ns/1ps
`include "adcsc_map.svh"

module adcsc_cal_file #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 10
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_we,
    input  wire logic [3:0]               i_waddr,
    input  wire logic [WIDTH-1:0]         i_wdata,
    input  wire logic [3:0]               i_raddr,
    output logic      [WIDTH-1:0]         o_rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } adcsc_cal_st_t;

    adcsc_cal_st_t st_reg;
    adcsc_cal_st_t st_next;

    // ****************************************
    // storage
    // ****************************************
    always_comb begin
        st_next = st_reg;
        if (i_we && (32'(i_waddr) < DEPTH)) begin
            st_next.mem[i_waddr] = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // out-of-range index reads zero rather than wrapping
    assign o_rdata = (32'(i_raddr) < DEPTH) ? st_reg.mem[i_raddr] : WIDTH'(`ADCSC_CAL_RST);

endmodule : adcsc_cal_file

// file: adcsc_regs.sv
`timescale 1ns/1ps
`include "adcsc_map.svh"

// How it works
// - status word is read only, sixteen bits
// - readback select 11 returns status next read
// - status word clears to zero at power-up
// - bit15 reads 0, bits 7:6 read 1
// - bit14 busy during conversion or calibration
// - bits 13:10 show channel selection
// - bits 9:8 show power-down select
// - bit5 interface mode, cleared each read
// - bit3 calibration kind, bit4 undefined
// - bit0 set while calibration runs
// - bits 2:1 show calibration target
// - ten readable writable calibration registers
// - calibration engine updates registers itself
// - target code chooses register access set
// - same target governs reads and writes
// - readback select 10 returns calibration data
// - pointer resets on control write, sequence end
// - pointer starts at gain, offset-only excepted
// - pointer auto-advances in multi-register sets
// - early stop, next control write resets
// - calibration reads carry two leading zeros
// - calibration start flag clears when done
// - offset word is zeros plus fourteen bits

module adcsc_regs #(
    parameter int CAL_W = 14,
    parameter int CAL_N = 10
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_ctrl_wr,
    input  wire logic [15:0]      i_ctrl_data,
    input  wire logic             i_cal_wr,
    input  wire logic [CAL_W-1:0] i_cal_wdata,
    input  wire logic             i_rd,
    input  wire logic [CAL_W-1:0] i_conv_result,
    input  wire logic             i_conv_busy,
    input  wire logic             i_cal_done,
    input  wire logic             i_eng_we,
    input  wire logic [3:0]       i_eng_idx,
    input  wire logic [CAL_W-1:0] i_eng_data,
    output logic      [15:0]      o_status,
    output logic      [15:0]      o_rd_data,
    output logic                  o_rd_valid,
    output logic                  o_cal_start_flag,
    output logic                  o_cal_kind_select,
    output logic      [1:0]       o_cal_target_sel,
    output logic                  o_single_ended_select,
    output logic      [2:0]       o_channel_sel,
    output logic      [1:0]       o_power_down_sel,
    output logic                  o_mode1,
    output logic      [3:0]       o_cal_ptr
);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rsync_reg;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rsync_reg <= 2'h0;
        end else begin
            rsync_reg <= {rsync_reg[0], 1'b1};
        end
    end

    assign rst_n = rsync_reg[1];

    // ****************************************
    // pointer helpers
    // ****************************************
    function automatic logic [3:0] first_idx(input adcsc_pkg::adcsc_tgt_t t);
        first_idx = (t == adcsc_pkg::ADCSC_TGT_OFF) ? `ADCSC_IDX_OFF : `ADCSC_IDX_GAIN;
    endfunction : first_idx

    function automatic logic [3:0] last_idx(input adcsc_pkg::adcsc_tgt_t t);
        case (t)
            adcsc_pkg::ADCSC_TGT_ALL:      last_idx = `ADCSC_IDX_LAST;
            adcsc_pkg::ADCSC_TGT_GAIN_OFF: last_idx = `ADCSC_IDX_OFF;
            adcsc_pkg::ADCSC_TGT_OFF:      last_idx = `ADCSC_IDX_OFF;
            default:                       last_idx = `ADCSC_IDX_GAIN;
        endcase
    endfunction : last_idx

    function automatic logic [3:0] step_ptr(input logic [3:0] p,
                                            input adcsc_pkg::adcsc_tgt_t t);
        if (p == last_idx(t)) begin
            step_ptr = first_idx(t);
        end else begin
            step_ptr = 4'(p + 4'h1);
        end
    endfunction : step_ptr

    // ****************************************
    // state
    // ****************************************
    adcsc_pkg::adcsc_top_st_t st_reg;
    adcsc_pkg::adcsc_top_st_t st_next;

    logic             cal_access;
    logic             host_we;
    logic             file_we;
    logic [3:0]       file_waddr;
    logic [CAL_W-1:0] file_wdata;
    logic [CAL_W-1:0] cal_q;
    logic             start_req;

    // host writes are locked out while the engine owns the file
    assign host_we    = i_cal_wr && !st_reg.cal_run;
    assign file_we    = (st_reg.cal_run && i_eng_we) || host_we;
    assign file_waddr = st_reg.cal_run ? i_eng_idx : st_reg.ptr;
    assign file_wdata = st_reg.cal_run ? i_eng_data : i_cal_wdata;
    // reads and writes share one pointer; the host keeps them apart
    assign cal_access = host_we || (i_rd && st_reg.rb == adcsc_pkg::ADCSC_RB_CAL);
    assign start_req  = i_ctrl_wr && i_ctrl_data[`ADCSC_CB_START];

    adcsc_cal_file #(
        .WIDTH (CAL_W),
        .DEPTH (CAL_N)
    ) u_cal_file (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_we    (file_we),
        .i_waddr (file_waddr),
        .i_wdata (file_wdata),
        .i_raddr (st_reg.ptr),
        .o_rdata (cal_q)
    );

    always_comb begin
        st_next          = st_reg;
        st_next.alive    = 1'b1;
        st_next.rd_valid = 1'b0;

        // read uses the selection in force before any same-cycle write
        if (i_rd) begin
            st_next.rd_valid = 1'b1;
            st_next.mode     = 1'b0;
            case (st_reg.rb)
                adcsc_pkg::ADCSC_RB_STAT: st_next.rd_data = st_reg.status;
                adcsc_pkg::ADCSC_RB_CAL:  st_next.rd_data = {`ADCSC_RD_LEAD, cal_q};
                default:                  st_next.rd_data = {`ADCSC_RD_LEAD, i_conv_result};
            endcase
        end

        if (cal_access) begin
            st_next.ptr = step_ptr(st_reg.ptr, st_reg.tgt);
        end

        if (st_reg.cal_run && i_cal_done) begin
            st_next.cal_run = 1'b0;
        end

        // status word itself takes no write; only control fields land
        if (i_ctrl_wr) begin
            st_next.sgl  = i_ctrl_data[`ADCSC_CB_SGL];
            st_next.ch   = i_ctrl_data[`ADCSC_CB_CH_HI:`ADCSC_CB_CH_LO];
            st_next.pm   = i_ctrl_data[`ADCSC_CB_PM_HI:`ADCSC_CB_PM_LO];
            st_next.rb   = adcsc_pkg::adcsc_rb_t'(i_ctrl_data[`ADCSC_CB_RB_HI:`ADCSC_CB_RB_LO]);
            st_next.mode = i_ctrl_data[`ADCSC_CB_MODE];
            st_next.kind = i_ctrl_data[`ADCSC_CB_KIND];
            st_next.tgt  = adcsc_pkg::adcsc_tgt_t'(i_ctrl_data[`ADCSC_CB_TGT_HI:`ADCSC_CB_TGT_LO]);
            st_next.ptr  = first_idx(st_next.tgt);
            if (start_req) begin
                st_next.cal_run = 1'b1;
            end
        end

        st_next.status = {1'b0,
                          i_conv_busy || st_reg.cal_run,
                          st_reg.sgl, st_reg.ch,
                          st_reg.pm,
                          `ADCSC_STAT_ID,
                          st_reg.mode,
                          1'b0,
                          st_reg.kind,
                          st_reg.tgt,
                          st_reg.cal_run};
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.status  <= `ADCSC_STAT_RST;
            st_reg.rd_data <= `ADCSC_RD_RST;
            st_reg.rb      <= adcsc_pkg::ADCSC_RB_RES_A;
            st_reg.tgt     <= adcsc_pkg::ADCSC_TGT_ALL;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_status              = st_reg.status;
    assign o_rd_data             = st_reg.rd_data;
    assign o_rd_valid            = st_reg.rd_valid;
    assign o_cal_start_flag      = st_reg.cal_run;
    assign o_cal_kind_select     = st_reg.kind;
    assign o_cal_target_sel      = st_reg.tgt;
    assign o_single_ended_select = st_reg.sgl;
    assign o_channel_sel         = st_reg.ch;
    assign o_power_down_sel      = st_reg.pm;
    assign o_mode1               = st_reg.mode;
    assign o_cal_ptr             = st_reg.ptr;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    a_status_fixed_bits: assert property (
        st_reg.alive |-> (st_reg.status[`ADCSC_SB_ZERO] == 1'b0) &&
                         (st_reg.status[`ADCSC_CB_RB_HI:`ADCSC_CB_RB_LO] == `ADCSC_STAT_ID))
        else $error("status fixed bits wrong");

    a_status_busy: assert property (
        st_reg.alive |-> st_reg.status[`ADCSC_SB_BUSY] == $past(i_conv_busy || st_reg.cal_run))
        else $error("busy bit does not follow activity");

    a_status_cal_bit: assert property (
        st_reg.alive |-> st_reg.status[`ADCSC_CB_START] == $past(st_reg.cal_run))
        else $error("calibration bit does not follow run flag");

    a_status_readback: assert property (
        (i_rd && st_reg.rb == adcsc_pkg::ADCSC_RB_STAT) |=>
            o_rd_valid && (o_rd_data == $past(st_reg.status)))
        else $error("status readback mismatch");

    a_mode_clear: assert property (
        (i_rd && !i_ctrl_wr) |=> !st_reg.mode ##1 !st_reg.status[`ADCSC_CB_MODE])
        else $error("mode bit not cleared after read");

    a_cal_leading: assert property (
        (i_rd && st_reg.rb == adcsc_pkg::ADCSC_RB_CAL) |=>
            (o_rd_data[15:14] == 2'h0) && (o_rd_data[13:0] == $past(cal_q)))
        else $error("calibration read word malformed");

    a_ptr_reset: assert property (
        i_ctrl_wr |=> st_reg.ptr == first_idx(st_reg.tgt))
        else $error("pointer not reset by control write");

    a_ptr_step: assert property (
        (cal_access && !i_ctrl_wr && st_reg.tgt == adcsc_pkg::ADCSC_TGT_ALL &&
         st_reg.ptr < `ADCSC_IDX_LAST) |=> st_reg.ptr == 4'($past(st_reg.ptr) + 4'h1))
        else $error("pointer did not advance");

    a_ptr_wrap: assert property (
        (cal_access && !i_ctrl_wr && st_reg.tgt == adcsc_pkg::ADCSC_TGT_ALL &&
         st_reg.ptr == `ADCSC_IDX_LAST) |=> st_reg.ptr == `ADCSC_IDX_GAIN)
        else $error("pointer did not wrap to gain");

    a_offset_only: assert property (
        (st_reg.tgt == adcsc_pkg::ADCSC_TGT_OFF && !i_ctrl_wr) |=> st_reg.ptr == `ADCSC_IDX_OFF)
        else $error("offset-only pointer moved");

    a_cal_clear: assert property (
        (st_reg.cal_run && i_cal_done && !start_req) |=> !o_cal_start_flag)
        else $error("calibration flag not cleared");

    a_status_fields: assert property (
        st_reg.alive |-> (st_reg.status[`ADCSC_CB_SGL:`ADCSC_CB_PM_LO] ==
                          $past({st_reg.sgl, st_reg.ch, st_reg.pm})) &&
                         (st_reg.status[`ADCSC_CB_KIND:`ADCSC_CB_TGT_LO] == $past({st_reg.kind, st_reg.tgt})))
        else $error("status control fields stale");

    // a host write racing the engine must not move the pointer
    a_host_locked: assert property (
        (st_reg.cal_run && i_cal_wr && !i_ctrl_wr && !i_rd) |=> st_reg.ptr == $past(st_reg.ptr))
        else $error("host write taken during calibration");

    a_rd_pulse: assert property (
        st_reg.alive |-> o_rd_valid == $past(i_rd))
        else $error("read valid not a one-cycle answer");

    a_conv_readback: assert property (
        (i_rd && (st_reg.rb == adcsc_pkg::ADCSC_RB_RES_A || st_reg.rb == adcsc_pkg::ADCSC_RB_RES_B)) |=>
            (o_rd_data == {`ADCSC_RD_LEAD, $past(i_conv_result)}))
        else $error("conversion readback mismatch");

    c_status_read: cover property (
        i_ctrl_wr && i_ctrl_data[`ADCSC_CB_RB_HI:`ADCSC_CB_RB_LO] == 2'h3 ##[1:4] i_rd);
    c_full_walk: cover property (
        cal_access && st_reg.tgt == adcsc_pkg::ADCSC_TGT_ALL && st_reg.ptr == `ADCSC_IDX_LAST);
    c_cal_done: cover property (
        st_reg.cal_run && i_cal_done);
    c_offset_only: cover property (
        cal_access && st_reg.tgt == adcsc_pkg::ADCSC_TGT_OFF);
    c_conv_read: cover property (
        i_rd && st_reg.rb == adcsc_pkg::ADCSC_RB_RES_B);

endmodule : adcsc_regs

// file: adcsc_host.sv
`timescale 1ns/1ps
// ****************************************
// host side of the word-level port
// ****************************************
module adcsc_host (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_valid,
    output logic             o_ctrl_wr,
    output logic      [15:0] o_ctrl_data,
    output logic             o_cal_wr,
    output logic      [13:0] o_cal_wdata,
    output logic             o_rd
);
    initial begin
        o_ctrl_wr   = 1'b0;
        o_ctrl_data = 16'h0000;
        o_cal_wr    = 1'b0;
        o_cal_wdata = 14'h0000;
        o_rd        = 1'b0;
    end

    // released data lines show the inverse, never a stale copy
    task automatic ctrl_write(input logic [15:0] d);
        @(posedge i_clk);
        o_ctrl_wr   <= 1'b1;
        o_ctrl_data <= d;
        @(posedge i_clk);
        o_ctrl_wr   <= 1'b0;
        o_ctrl_data <= ~d;
    endtask : ctrl_write

    // callers keep one sequence all writes or all reads
    task automatic cal_write(input logic [13:0] d);
        @(posedge i_clk);
        o_cal_wr    <= 1'b1;
        o_cal_wdata <= d;
        @(posedge i_clk);
        o_cal_wr    <= 1'b0;
        o_cal_wdata <= ~d;
    endtask : cal_write

    task automatic read_word(output logic [15:0] d, output logic v);
        @(posedge i_clk);
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rd_data;
        v = i_rd_valid;
    endtask : read_word
endmodule : adcsc_host

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        i_clk, i_rstn, i_ctrl_wr, i_cal_wr, i_rd, i_conv_busy, i_cal_done, i_eng_we;
    logic [15:0] i_ctrl_data, o_status, o_rd_data, d, rd;
    logic [13:0] i_cal_wdata, i_conv_result, i_eng_data;
    logic [13:0] cal_ref [10];
    logic [3:0]  i_eng_idx, o_cal_ptr;
    logic [2:0]  o_channel_sel;
    logic [1:0]  o_cal_target_sel, o_power_down_sel, tg;
    logic        o_rd_valid, o_cal_start_flag, o_cal_kind_select, o_single_ended_select, o_mode1, v;
    int          failures, cmp_count, seed, t, k;

    adcsc_regs adcsc_regs_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_ctrl_wr(i_ctrl_wr), .i_ctrl_data(i_ctrl_data),
        .i_cal_wr(i_cal_wr), .i_cal_wdata(i_cal_wdata), .i_rd(i_rd), .i_conv_result(i_conv_result),
        .i_conv_busy(i_conv_busy), .i_cal_done(i_cal_done), .i_eng_we(i_eng_we), .i_eng_idx(i_eng_idx),
        .i_eng_data(i_eng_data), .o_status(o_status), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_cal_start_flag(o_cal_start_flag), .o_cal_kind_select(o_cal_kind_select),
        .o_cal_target_sel(o_cal_target_sel), .o_single_ended_select(o_single_ended_select),
        .o_channel_sel(o_channel_sel), .o_power_down_sel(o_power_down_sel), .o_mode1(o_mode1),
        .o_cal_ptr(o_cal_ptr));
    adcsc_host host_i (.i_clk(i_clk), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid), .o_ctrl_wr(i_ctrl_wr),
        .o_ctrl_data(i_ctrl_data), .o_cal_wr(i_cal_wr), .o_cal_wdata(i_cal_wdata), .o_rd(i_rd));

    // ****************************************
    // expectations
    // ****************************************
    function automatic logic [15:0] exp_status(input logic [15:0] c, input logic busy, input logic run);
        exp_status = {1'b0, busy, c[13:8], 2'b11, c[5], 1'b0, c[3:1], run};
    endfunction : exp_status
    function automatic int set_len(input logic [1:0] g);
        set_len = (g == 2'h0) ? 10 : ((g == 2'h1) ? 2 : 1);
    endfunction : set_len
    function automatic logic [3:0] ptr_at(input logic [1:0] g, input int n);
        ptr_at = ((g == 2'h2) ? 4'h1 : 4'h0) + 4'(n % set_len(g));
    endfunction : ptr_at

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // first n words of a set read back in pointer order
    task automatic read_set(input logic [1:0] g, input int n);
        for (int j = 0; j < n; j++) begin
            host_i.read_word(rd, v);
            check(rd, {2'b00, cal_ref[ptr_at(g, j)]});
            check({12'h000, o_cal_ptr}, {12'h000, ptr_at(g, j + 1)});
        end
    endtask : read_set

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        #100000;
        failures++;
        give_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 52;
        failures = 0;
        cmp_count = 0;
        i_rstn = 1'b0;
        i_conv_busy = 1'b0;
        i_conv_result = 14'h0000;
        i_cal_done = 1'b0;
        i_eng_we = 1'b0;
        i_eng_idx = 4'h0;
        i_eng_data = 14'h0000;
        repeat (10) @(posedge i_clk);
        #1 check(o_status, 16'h0000);
        @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (5) @(posedge i_clk);
        #1 check(o_status, 16'h00c0);
        for (k = 0; k < 24; k++) begin
            d = 16'($random(seed));
            d[7:6] = 2'b11;
            d[0] = 1'b0;
            @(posedge i_clk);
            i_conv_busy <= d[15];
            i_conv_result <= 14'($random(seed));
            host_i.ctrl_write(d);
            #1 check({6'h00, o_single_ended_select, o_channel_sel, o_power_down_sel, o_mode1, o_cal_kind_select,
                o_cal_target_sel}, {6'h00, d[13:8], d[5], d[3:1]});
            @(posedge i_clk);
            #1 check(o_status, exp_status(d, d[15], 1'b0));
            host_i.read_word(rd, v);
            check(rd, exp_status(d, d[15], 1'b0));
            check({15'h0000, v & ~o_mode1}, 16'h0001);
            @(posedge i_clk);
            #1 check(o_status, exp_status(d & 16'hffdf, d[15], 1'b0));
        end
        i_conv_busy <= 1'b0;
        for (t = 0; t < 4; t++) begin
            tg = 2'(t);
            host_i.ctrl_write({8'h00, 2'b10, 3'h0, tg, 1'b0});
            #1 check({12'h000, o_cal_ptr}, {12'h000, ptr_at(tg, 0)});
            for (k = 0; k < set_len(tg); k++) begin
                cal_ref[ptr_at(tg, k)] = 14'($random(seed));
                host_i.cal_write(cal_ref[ptr_at(tg, k)]);
                #1 check({12'h000, o_cal_ptr}, {12'h000, ptr_at(tg, k + 1)});
            end
            read_set(tg, set_len(tg));
        end
        host_i.ctrl_write(16'h0080);
        read_set(2'h0, 3);
        host_i.ctrl_write(16'h0080);
        #1 check({12'h000, o_cal_ptr}, 16'h0000);
        d = 16'h00c9;
        host_i.ctrl_write(d);
        #1 check({15'h0000, o_cal_start_flag}, 16'h0001);
        @(posedge i_clk);
        #1 check(o_status, exp_status(d, 1'b1, 1'b1));
        host_i.cal_write(14'h3fff);
        #1 check({12'h000, o_cal_ptr}, 16'h0000);
        for (k = 0; k < 10; k++) begin
            @(posedge i_clk);
            cal_ref[k] = 14'($random(seed));
            i_eng_we <= 1'b1;
            i_eng_idx <= 4'(k);
            i_eng_data <= cal_ref[k];
        end
        @(posedge i_clk);
        i_eng_we <= 1'b0;
        i_cal_done <= 1'b1;
        @(posedge i_clk);
        i_cal_done <= 1'b0;
        #1 check({15'h0000, o_cal_start_flag}, 16'h0000);
        @(posedge i_clk);
        #1 check(o_status, exp_status(d, 1'b0, 1'b0));
        host_i.ctrl_write(16'h0080);
        read_set(2'h0, 10);
        i_conv_result <= 14'($random(seed));
        host_i.ctrl_write(16'h0040);
        host_i.read_word(rd, v);
        check(rd, {2'b00, i_conv_result});
        host_i.ctrl_write(16'h3f04);
        @(posedge i_clk);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        #1 check(o_status, 16'h0000);
        check({12'h000, o_cal_ptr}, 16'h0000);
        @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (5) @(posedge i_clk);
        #1 check(o_status, 16'h00c0);
        give_verdict();
    end
endmodule : testbench
